//--- verif/contact_bank.sv
// Purpose: contact terminals with bounce on every change
// Assumes: bit 10 stop, 9 reset, 8 jog, 7 fwd, 6 rev, 5..0 general
// Notes: changed bits chatter for three cycles, then settle
`timescale 1ns/1ps
module contact_bank (
	input wire logic clk_sys,
	input wire logic [10:0] want,
	output logic [10:0] pins
);
	logic [10:0] last = '0;
	logic [10:0] diff = '0;
	logic [1:0] cnt = '0;
	initial pins = '0;
	always @(posedge clk_sys) begin
		last <= want;
		if (want != last) begin
			diff <= want ^ last;
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
		pins <= want ^ (cnt[0] ? diff : 11'h000);
	end
endmodule

//--- verif/input_decoder_chk.sv
// Purpose: port-level checks of the input decoder
// Assumes: filter constant set to 0 before stop inputs are used
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
module input_decoder_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic emergency_stop_input,
	input wire logic driveStopped,
	input wire logic injection_brake_request,
	input wire logic drive_line_select,
	input wire logic mains_line_select,
	input wire logic speedSearch,
	input wire logic outputCutoff,
	input wire logic faultLatched,
	input wire logic [2:0] sequenceNumber,
	input wire logic sequenceActive
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	lines_apart_a: assert property (!(drive_line_select && mains_line_select))
		else $error("both line selects high");
	gap_mains_a: assert property ($fell(drive_line_select) |-> !mains_line_select[*8])
		else $error("mains select without dead interval");
	gap_drive_a: assert property ($fell(mains_line_select) |-> !drive_line_select[*8])
		else $error("drive select without dead interval");
	search_mains_a: assert property (mains_line_select |-> speedSearch)
		else $error("speed search low on mains line");
	brake_stopped_a: assert property (injection_brake_request |-> $past(driveStopped))
		else $error("brake while running");
	estop_cut_a: assert property (emergency_stop_input[*8] |=> outputCutoff)
		else $error("output not cut on stop input");
	estop_abort_a: assert property (emergency_stop_input[*8] |=> !sequenceActive)
		else $error("sequence survives stop input");
	fault_cut_a: assert property (faultLatched[*2] |-> outputCutoff)
		else $error("latched fault without cutoff");
	seq_range_a: assert property (sequenceActive[*2] |-> sequenceNumber inside {[1:5]})
		else $error("sequence number out of range");
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access phase answer missing");
	unmapped_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("error read not zero");
endmodule

//--- verif/tb_top.sv
// Purpose: self-checking bench for the input decoder
// Assumes: filter constant 0, short interlock and step times
// Notes: random terminal patterns from a fixed seed
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	localparam int IL = 20;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, driveStopped = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err;
	logic [10:0] want = '0, pins;
	logic [2:0] rampSelect, sequenceNumber, sequenceStep;
	logic injection_brake_request, drive_line_select, mains_line_select, speedSearch;
	logic outputCutoff, faultLatched, integral_clear, openLoop, localSource, freqHold;
	logic ramp_freeze, alt_proportional_gain, currentRefSelect, runCommand;
	logic sequenceActive, manualMode;
	int errors = 0, n_tests = 0, cyc = 0, n;
	logic [4:0] fl[9] = '{5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h12, 5'h15};
	logic [2:0] code[5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
	always #25 clk_sys = ~clk_sys;
	input_decoder #(.INTERLOCK_CYCLES(IL), .STEP_TIME_CYCLES(10)) uut (.clk_sys, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.generalInput(pins[5:0]), .reverseRunInput(pins[6]), .forward_run_input(pins[7]),
		.jogInput(pins[8]), .resetInput(pins[9]), .emergency_stop_input(pins[10]),
		.driveStopped, .rampSelect, .injection_brake_request, .drive_line_select,
		.mains_line_select, .speedSearch, .outputCutoff, .faultLatched, .integral_clear,
		.openLoop, .localSource, .freqHold, .ramp_freeze, .alt_proportional_gain,
		.currentRefSelect, .runCommand, .sequenceNumber, .sequenceStep, .sequenceActive,
		.manualMode);
	contact_bank contacts (.clk_sys, .want, .pins);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic pick(input logic [4:0] f);
		case (f)
			5'h04: return injection_brake_request;
			5'h09: return integral_clear;
			5'h0A: return openLoop;
			5'h0B: return localSource;
			5'h0C: return freqHold;
			5'h0D: return ramp_freeze;
			5'h0E: return alt_proportional_gain;
			5'h12: return manualMode;
			default: return currentRefSelect;
		endcase
	endfunction
	function automatic logic [2:0] seqOf(input logic [2:0] c);
		return (c == 3'h4) ? 3'h3 : (c == 3'h3) ? 3'h4 : c;
	endfunction
	task automatic wait_n(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic set_wait(input logic [10:0] v);
		want <= v;
		wait_n(14);
	endtask
	task automatic xchg(input logic toMains);
		want <= {10'h000, toMains};
		for (n = 0; n < 30 && (toMains ? drive_line_select : mains_line_select); n++)
			@(posedge clk_sys);
		for (n = 0; n < 60 && !(toMains ? mains_line_select : drive_line_select); n++) begin
			`CHK(speedSearch, 1'b1)
			@(posedge clk_sys);
		end
		`CHK(n >= IL - 1 && n <= IL + 2, 1'b1)
	endtask
	task automatic end_sim;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			errors++;
			end_sim;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		v = $urandom(32'h0E118FA3);
		wait_n(6);
		rst_n <= 1'b1;
		wait_n(1);
		rchk(12'h004, 32'h0000000F);
		rchk(12'h008, 32'h00000000);
		apb(12'h020, 1'b0, 32'h0);
		`CHK(err, 1'b1)
		apb(12'h004, 1'b1, 32'h0);
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			set_wait({2'b00, v[8:0]});
			rchk(12'h000, {23'h0, v[8:0]});
		end
		want <= '0;
		apb(12'h008, 1'b1, 32'h00000C41);
		v = $urandom;
		for (int i = 0; i < 8; i++) begin
			set_wait({8'h00, i[2:0] ^ v[2:0]});
			`CHK(rampSelect, i[2:0] ^ v[2:0])
		end
		for (int i = 0; i < 9; i++) begin
			apb(12'h008, 1'b1, {27'h0, fl[i]});
			driveStopped <= 1'b0;
			set_wait(11'h001);
			`CHK(pick(fl[i]), !(fl[i] inside {5'h04, 5'h0A, 5'h0B, 5'h12}))
			driveStopped <= 1'b1;
			wait_n(14);
			`CHK(pick(fl[i]), 1'b1)
			set_wait(11'h000);
			`CHK(pick(fl[i]), 1'b0)
		end
		set_wait(11'h020);
		apb(12'h008, 1'b1, 32'h10700000);
		wait_n(4);
		`CHK(faultLatched, 1'b0)
		set_wait(11'h030);
		`CHK({faultLatched, outputCutoff}, 2'b11)
		set_wait(11'h020);
		`CHK(faultLatched, 1'b1)
		set_wait(11'h220);
		set_wait(11'h020);
		`CHK({faultLatched, outputCutoff}, 2'b00)
		set_wait(11'h000);
		`CHK({faultLatched, outputCutoff}, 2'b11)
		set_wait(11'h220);
		set_wait(11'h420);
		`CHK({faultLatched, outputCutoff}, 2'b01)
		apb(12'h008, 1'b1, 32'h00000005);
		`CHK(drive_line_select, 1'b1)
		xchg(1'b1);
		xchg(1'b0);
		apb(12'h008, 1'b1, 32'h0149C60F);
		for (int i = 0; i < 5; i++) begin
			set_wait({8'h00, code[i]});
			want <= {4'h1, 4'h0, code[i]};
			for (n = 0; n < 30 && !sequenceActive; n++)
				@(posedge clk_sys);
			`CHK(sequenceNumber, seqOf(code[i]))
			want <= {8'h00, code[i]};
			v = 0;
			for (n = 0; n < 300 && sequenceActive; n++) begin
				if (sequenceStep > v[2:0]) v[2:0] = sequenceStep;
				@(posedge clk_sys);
			end
			`CHK({sequenceActive, v[2:0]}, 4'h7)
		end
		set_wait(11'h091);
		want <= 11'h011;
		wait_n(110);
		`CHK({sequenceActive, sequenceStep}, 4'hF)
		set_wait(11'h001);
		`CHK(sequenceActive, 1'b0)
		apb(12'h00C, 1'b1, 32'h00000004);
		set_wait(11'h081);
		set_wait(11'h009);
		// unfiltered bounce gives three rising edges of go-step
		`CHK({sequenceActive, sequenceStep}, 4'hB)
		set_wait(11'h401);
		`CHK(sequenceActive, 1'b0)
		set_wait(11'h000);
		apb(12'h008, 1'b1, 32'h00000186);
		apb(12'h00C, 1'b1, 32'h00000003);
		set_wait(11'h003);
		`CHK({runCommand, freqHold}, 2'b00)
		set_wait(11'h083);
		set_wait(11'h003);
		`CHK(runCommand, 1'b1)
		set_wait(11'h002);
		`CHK(runCommand, 1'b0)
		end_sim;
	end
endmodule
bind input_decoder input_decoder_chk chk (.clk_sys, .rst_n, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .emergency_stop_input, .driveStopped,
	.injection_brake_request, .drive_line_select, .mains_line_select, .speedSearch,
	.outputCutoff, .faultLatched, .sequenceNumber, .sequenceActive);

//--- verilog/input_decoder.sv
// Purpose: multifunction input terminal decoder and sequencer
// Assumes: APB slave, single clock, contact inputs asynchronous
// Notes: analog path and motor control live elsewhere
//
// Notes on behaviour
// [RQ1] three ramp bits select one of eight pairs
// [RQ2] injection brake only while stopped and closed
// [RQ3] dead interval between line select changes
// [RQ4] speed search active during whole exchange
// [RQ5] three-wire latches start, stop freezes ramp
// [RQ6] open-contact trip active high latches fault
// [RQ7] closed-contact trip active low latches fault
// [RQ8] integral clear forces integral to zero
// [RQ9] open-loop switch accepted only while stopped
// [RQ10] main-drive source switch only while stopped
// [RQ11] analog hold freezes frequency while asserted
// [RQ12] ramp freeze suspends accel and decel
// [RQ13] gain swap uses alternate proportional gain
// [RQ14] sequence select decodes five sequences
// [RQ15] sequence runs all steps, estop aborts
// [RQ16] manual switch accepted only while stopped
// [RQ17] external step advance in stepped mode
// [RQ18] step hold keeps final step frequency; code ends the sequence instead in stepped mode
// [RQ19] fault reset clears latched faults
// [RQ20] emergency stop cuts output at once
// [RQ21] reference swap selects current analog input; code keeps the previous selection while emergency stop is active
// [RQ22] nine-bit terminal status word
// [RQ23] filter time is constant times half millisecond
// [RQ24] synchronous sampling, per-input function assignment
`timescale 1ns/1ps
`include "input_decoder_cfg.svh"
module input_decoder #(
	parameter int INTERLOCK_CYCLES = `INTERLOCK_CYC,
	parameter int STEP_TIME_CYCLES = 20000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] generalInput,
	input wire logic reverseRunInput,
	input wire logic forward_run_input,
	input wire logic jogInput,
	input wire logic resetInput,
	input wire logic emergency_stop_input,
	input wire logic driveStopped,
	output logic [2:0] rampSelect,
	output logic injection_brake_request,
	output logic drive_line_select,
	output logic mains_line_select,
	output logic speedSearch,
	output logic outputCutoff,
	output logic faultLatched,
	output logic integral_clear,
	output logic openLoop,
	output logic localSource,
	output logic freqHold,
	output logic ramp_freeze,
	output logic alt_proportional_gain,
	output logic currentRefSelect,
	output logic runCommand,
	output logic [2:0] sequenceNumber,
	output logic [2:0] sequenceStep,
	output logic sequenceActive,
	output logic manualMode
);
	// ------------------------------------------------------------
	// terminal filtering
	// ------------------------------------------------------------
	localparam int NTERM = 11;
	localparam int CNT_W = 24;
	logic [7:0] filterConst;
	logic [29:0] funcMap;
	logic [7:0] control;
	logic [NTERM-1:0] raw;
	logic [NTERM-1:0] lvl;
	logic [CNT_W-1:0] window;

	assign raw = {emergency_stop_input, resetInput, jogInput, forward_run_input,
		reverseRunInput, generalInput};
	// window = constant times half-millisecond unit
	assign window = CNT_W'(filterConst * `FILTER_UNIT_CYC); // [RQ23]

	genvar gi;
	generate
		for (gi = 0; gi < NTERM; gi++) begin : g_filt
			input_filter #(.CNT_W(CNT_W)) u_filt ( // [RQ24]
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.rawIn(raw[gi]),
				.window(window),
				.level(lvl[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// function routing
	// ------------------------------------------------------------
	logic [31:0] fn;
	always_comb begin
		fn = '0;
		for (int i = 0; i < 6; i++) begin
			if (lvl[i]) begin
				fn[funcMap[i*5 +: 5]] = 1'b1; // [RQ24]
			end
		end
	end

	// trip-b contact: missing closure means asserted
	logic tripNcOpen;
	always_comb begin
		tripNcOpen = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (funcMap[i*5 +: 5] == 5'(input_decoder_pkg::FN_TRIP_NC) && !lvl[i]) begin
				tripNcOpen = 1'b1; // [RQ7]
			end
		end
	end

	logic estop;
	logic fwdRun;
	assign estop = lvl[10];
	assign fwdRun = lvl[7];

	// ------------------------------------------------------------
	// faults and stop
	// ------------------------------------------------------------
	logic tripEvent;
	assign tripEvent = fn[input_decoder_pkg::FN_TRIP_NO] | tripNcOpen; // [RQ6]
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			faultLatched <= 1'b0;
		end else if (tripEvent) begin
			faultLatched <= 1'b1; // [RQ6]
		end else if (lvl[9]) begin
			faultLatched <= 1'b0; // [RQ19]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			outputCutoff <= 1'b0;
		end else begin
			outputCutoff <= estop | tripEvent | faultLatched; // [RQ20]
		end
	end

	// ------------------------------------------------------------
	// simple command outputs
	// ------------------------------------------------------------
	logic stopped;
	assign stopped = driveStopped;
	logic threeWire;
	logic runLatch;
	assign threeWire = control[0];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rampSelect <= 3'h0;
			injection_brake_request <= 1'b0;
			integral_clear <= 1'b0;
			freqHold <= 1'b0;
			ramp_freeze <= 1'b0;
			alt_proportional_gain <= 1'b0;
			currentRefSelect <= 1'b0;
		end else begin
			rampSelect <= {fn[input_decoder_pkg::FN_RAMP2], fn[input_decoder_pkg::FN_RAMP1],
				fn[input_decoder_pkg::FN_RAMP0]}; // [RQ1]
			injection_brake_request <= stopped & fn[input_decoder_pkg::FN_BRAKE]; // [RQ2]
			integral_clear <= fn[input_decoder_pkg::FN_ICLEAR]; // [RQ8]
			freqHold <= fn[input_decoder_pkg::FN_ANA_HOLD] & ~control[1]; // [RQ11]
			// stop push-button open in three-wire freezes the ramp for one cycle, until runLatch clears
			ramp_freeze <= fn[input_decoder_pkg::FN_FREEZE] // [RQ12]
				| (threeWire & ~fn[input_decoder_pkg::FN_THREE_WIRE] & runLatch); // [RQ5]
			alt_proportional_gain <= fn[input_decoder_pkg::FN_ALT_GAIN]; // [RQ13]
			currentRefSelect <= lvl[10] ? currentRefSelect : fn[input_decoder_pkg::FN_REF_SWAP]; // [RQ21]
		end
	end

	// mode switches sampled only while stopped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			openLoop <= 1'b0;
			localSource <= 1'b0;
			manualMode <= 1'b0;
		end else if (stopped) begin
			openLoop <= fn[input_decoder_pkg::FN_OPEN_LOOP]; // [RQ9]
			localSource <= fn[input_decoder_pkg::FN_MAIN_DRIVE]; // [RQ10]
			manualMode <= fn[input_decoder_pkg::FN_MANUAL]; // [RQ16]
		end
	end

	// three-wire: start latches, stop contact opening releases
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			runLatch <= 1'b0;
		end else if (estop || !fn[input_decoder_pkg::FN_THREE_WIRE]) begin
			runLatch <= 1'b0; // [RQ5]
		end else if (fwdRun) begin
			runLatch <= 1'b1; // [RQ5]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			runCommand <= 1'b0;
		end else begin
			runCommand <= ~estop & ~faultLatched & (threeWire ? runLatch : fwdRun); // [RQ20]
		end
	end

	// ------------------------------------------------------------
	// line exchange
	// ------------------------------------------------------------
	input_decoder_pkg::xchg_t xs;
	logic [31:0] gapCount;
	logic xreq;
	assign xreq = fn[input_decoder_pkg::FN_EXCHANGE];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			xs <= input_decoder_pkg::XS_DRIVE;
			gapCount <= '0;
		end else begin
			case (xs)
				input_decoder_pkg::XS_DRIVE: begin
					gapCount <= '0;
					if (xreq) xs <= input_decoder_pkg::XS_GAP_TO_MAINS;
				end
				input_decoder_pkg::XS_GAP_TO_MAINS: begin
					gapCount <= gapCount + 1;
					if (gapCount >= 32'(INTERLOCK_CYCLES - 1)) begin
						xs <= input_decoder_pkg::XS_MAINS; // [RQ3]
					end
				end
				input_decoder_pkg::XS_MAINS: begin
					gapCount <= '0;
					if (!xreq) xs <= input_decoder_pkg::XS_GAP_TO_DRIVE;
				end
				input_decoder_pkg::XS_GAP_TO_DRIVE: begin
					gapCount <= gapCount + 1;
					if (gapCount >= 32'(INTERLOCK_CYCLES - 1)) begin
						xs <= input_decoder_pkg::XS_DRIVE; // [RQ3]
					end
				end
				default: xs <= input_decoder_pkg::XS_DRIVE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			drive_line_select <= 1'b0;
			mains_line_select <= 1'b0;
			speedSearch <= 1'b0;
		end else begin
			drive_line_select <= (xs == input_decoder_pkg::XS_DRIVE); // [RQ3]
			mains_line_select <= (xs == input_decoder_pkg::XS_MAINS); // [RQ3]
			speedSearch <= (xs != input_decoder_pkg::XS_DRIVE) | xreq; // [RQ4]
		end
	end

	// ------------------------------------------------------------
	// auto sequence
	// ------------------------------------------------------------
	input_decoder_pkg::seq_t sq;
	logic [2:0] selCode;
	logic [2:0] decoded;
	logic [31:0] stepCount;
	logic goPrev;
	logic goEdge;
	logic steppedMode;
	assign selCode = {fn[input_decoder_pkg::FN_SEQ2], fn[input_decoder_pkg::FN_SEQ1],
		fn[input_decoder_pkg::FN_SEQ0]};
	assign steppedMode = control[2];
	assign goEdge = fn[input_decoder_pkg::FN_GO_STEP] & ~goPrev;

	always_comb begin
		case (selCode)
			3'b001: decoded = 3'h1; // [RQ14]
			3'b010: decoded = 3'h2;
			3'b100: decoded = 3'h3;
			3'b011: decoded = 3'h4;
			3'b101: decoded = 3'h5;
			default: decoded = 3'h0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			goPrev <= 1'b0;
		end else begin
			goPrev <= fn[input_decoder_pkg::FN_GO_STEP];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sq <= input_decoder_pkg::SQ_IDLE;
			sequenceStep <= 3'h0;
			sequenceNumber <= 3'h0;
			stepCount <= '0;
		end else if (estop) begin
			sq <= input_decoder_pkg::SQ_IDLE; // [RQ15]
			sequenceStep <= 3'h0;
			stepCount <= '0;
		end else begin
			case (sq)
				input_decoder_pkg::SQ_IDLE: begin
					stepCount <= '0;
					sequenceStep <= 3'h0;
					if (!manualMode && decoded != 3'h0 && fwdRun) begin
						sequenceNumber <= decoded; // [RQ14]
						sq <= input_decoder_pkg::SQ_RUN;
					end
				end
				input_decoder_pkg::SQ_RUN: begin
					if (steppedMode) begin
						if (goEdge) sq <= input_decoder_pkg::SQ_WAIT; // [RQ17]
					end else begin
						stepCount <= stepCount + 1;
						if (stepCount >= 32'(STEP_TIME_CYCLES - 1)) begin
							sq <= input_decoder_pkg::SQ_WAIT;
						end
					end
				end
				input_decoder_pkg::SQ_WAIT: begin
					stepCount <= '0;
					if (sequenceStep == 3'(`SEQ_STEPS - 1)) begin
						if (!steppedMode && fn[input_decoder_pkg::FN_HOLD_STEP]) begin
							sq <= input_decoder_pkg::SQ_HOLD; // [RQ18]
						end else begin
							sq <= input_decoder_pkg::SQ_IDLE; // [RQ15]
						end
					end else begin
						sequenceStep <= sequenceStep + 3'h1; // [RQ17]
						sq <= input_decoder_pkg::SQ_RUN;
					end
				end
				input_decoder_pkg::SQ_HOLD: begin
					if (!fn[input_decoder_pkg::FN_HOLD_STEP]) sq <= input_decoder_pkg::SQ_IDLE;
				end
				default: sq <= input_decoder_pkg::SQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sequenceActive <= 1'b0;
		end else begin
			sequenceActive <= (sq != input_decoder_pkg::SQ_IDLE) && !estop; // [RQ15]
		end
	end

	// ------------------------------------------------------------
	// apb registers
	// ------------------------------------------------------------
	logic [8:0] status;
	logic wrEn;
	logic known;
	// status bits: general inputs, reverse, forward, jog
	assign status = lvl[8:0]; // [RQ22]
	assign wrEn = psel & penable & pwrite;
	assign known = (paddr == `REG_STATUS_OFFSET) || (paddr == `REG_FILTER_OFFSET)
		|| (paddr == `REG_FUNC_OFFSET) || (paddr == `REG_CONTROL_OFFSET)
		|| (paddr == `REG_COMMAND_OFFSET) || (paddr == `REG_SEQSTEP_OFFSET);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			filterConst <= `FILTER_RESET;
			funcMap <= `FUNC_RESET;
			control <= `CTRL_RESET;
		end else if (wrEn) begin
			if (paddr == `REG_FILTER_OFFSET) filterConst <= pwdata[7:0];
			if (paddr == `REG_FUNC_OFFSET) funcMap <= pwdata[29:0];
			if (paddr == `REG_CONTROL_OFFSET) control <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~known;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`REG_STATUS_OFFSET: prdata <= {23'h0, status};
					`REG_FILTER_OFFSET: prdata <= {24'h0, filterConst};
					`REG_FUNC_OFFSET: prdata <= {2'h0, funcMap};
					`REG_CONTROL_OFFSET: prdata <= {24'h0, control};
					`REG_COMMAND_OFFSET: prdata <= {16'h0, runCommand, outputCutoff,
						faultLatched, speedSearch, mains_line_select, drive_line_select,
						injection_brake_request, integral_clear, openLoop, localSource,
						freqHold, ramp_freeze, alt_proportional_gain, currentRefSelect,
						manualMode, sequenceActive};
					`REG_SEQSTEP_OFFSET: prdata <= {24'h0, 2'h0, sequenceNumber, sequenceStep};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule

//--- verilog/input_decoder_cfg.svh
// Purpose: constants for the multifunction input decoder
// Assumes: 32-bit APB, word aligned registers
// Notes: offsets are byte addresses
`ifndef INPUT_DECODER_CFG_SVH
`define INPUT_DECODER_CFG_SVH

`define REG_STATUS_OFFSET 12'h000
`define REG_FILTER_OFFSET 12'h004
`define REG_FUNC_OFFSET 12'h008
`define REG_CONTROL_OFFSET 12'h00C
`define REG_COMMAND_OFFSET 12'h010
`define REG_SEQSTEP_OFFSET 12'h014
`define FILTER_RESET 8'h0F
`define FILTER_UNIT_US 500
`define CLK_MHZ 20
`define FILTER_UNIT_CYC ((`FILTER_UNIT_US * `CLK_MHZ))
`define INTERLOCK_MS 50
`define INTERLOCK_CYC ((`INTERLOCK_MS * 1000 * `CLK_MHZ))
`define SEQ_STEPS 8
`define FUNC_RESET 30'h0
`define CTRL_RESET 8'h00

`endif

//--- verilog/input_decoder_pkg.sv
// Purpose: types for the multifunction input decoder
// Assumes: nothing
// Notes: function codes are per general input
package input_decoder_pkg;
	typedef enum logic [4:0] {
		FN_NONE = 5'h00, FN_RAMP0 = 5'h01, FN_RAMP1 = 5'h02, FN_RAMP2 = 5'h03,
		FN_BRAKE = 5'h04, FN_EXCHANGE = 5'h05, FN_THREE_WIRE = 5'h06,
		FN_TRIP_NO = 5'h07, FN_TRIP_NC = 5'h08, FN_ICLEAR = 5'h09,
		FN_OPEN_LOOP = 5'h0A, FN_MAIN_DRIVE = 5'h0B, FN_ANA_HOLD = 5'h0C,
		FN_FREEZE = 5'h0D, FN_ALT_GAIN = 5'h0E, FN_SEQ0 = 5'h0F,
		FN_SEQ1 = 5'h10, FN_SEQ2 = 5'h11, FN_MANUAL = 5'h12, FN_GO_STEP = 5'h13,
		FN_HOLD_STEP = 5'h14, FN_REF_SWAP = 5'h15
	} func_t;
	typedef enum logic [1:0] {
		XS_DRIVE = 2'b00, XS_GAP_TO_MAINS = 2'b01, XS_MAINS = 2'b11, XS_GAP_TO_DRIVE = 2'b10
	} xchg_t;
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00, SQ_RUN = 2'b01, SQ_WAIT = 2'b11, SQ_HOLD = 2'b10
	} seq_t;
endpackage

//--- verilog/input_filter.sv
// Purpose: two-flop sync plus debounce of one terminal
// Assumes: filter constant times unit ticks
// Notes: output changes after input is stable for the window
`timescale 1ns/1ps
module input_filter #(
	parameter int CNT_W = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic rawIn,
	input wire logic [CNT_W-1:0] window,
	output logic level
);
	logic syncA;
	logic syncB;
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= rawIn;
			syncB <= syncA;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count <= '0;
			level <= 1'b0;
		end else if (syncB == level) begin
			count <= '0;
		end else if (count >= window) begin
			level <= syncB;
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end
endmodule
